// *** design/mrd_addr_pkg.sv ***
package mrd_addr_pkg;
   // ----------------------------------------
   // widths
   // ----------------------------------------
   localparam int ADDR_W = 32;
   localparam int CBE_W  = 4;
   localparam int STAT_W = 4;
   localparam int LEN_W  = 16;
   // ----------------------------------------
   // local status codes
   // ----------------------------------------
   localparam logic [3:0] STAT_IDLE     = 4'h0;
   localparam logic [3:0] STAT_ADDR_LD  = 4'h1;
   localparam logic [3:0] STAT_BUS_XFER = 4'h2;
   // ----------------------------------------
   // reset values
   // ----------------------------------------
   localparam logic [31:0] AD_RST  = 32'h0000_0000;
   localparam logic [3:0]  CBE_RST = 4'h0;
   typedef enum logic [2:0] {
      ST_IDLE,
      ST_REQ,
      ST_GRANT,
      ST_LOAD,
      ST_ADDR,
      ST_TURN,
      ST_DATA
   } mst_state_t;
endpackage

// *** design/addr_latch_if.sv ***
`timescale 1ns/100ps
`default_nettype none
interface addr_latch_if #(
   parameter int LEN_W = 16
);
   logic                 load;
   logic [31:0]          addr_in;
   logic [3:0]           cmd_in;
   logic [LEN_W-1:0]     len_in;
   logic [31:0]          addr;
   logic [3:0]           cmd;
   logic [LEN_W-1:0]     len;
   modport ctrl  (output load, addr_in, cmd_in, len_in, input addr, cmd, len);
   modport store (input load, addr_in, cmd_in, len_in, output addr, cmd, len);
endinterface
`default_nettype wire

// *** design/addr_latch.sv ***
`timescale 1ns/100ps
`default_nettype none
module addr_latch (
   input  wire logic   clock,
   input  wire logic   reset_n,
   addr_latch_if.store lat
);
   // ----------------------------------------
   // held from load until the next load or reset
   // ----------------------------------------
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         lat.addr <= mrd_addr_pkg::AD_RST;
         lat.cmd  <= mrd_addr_pkg::CBE_RST;
         lat.len  <= '0;
      end else if (lat.load) begin
         lat.addr <= lat.addr_in;
         lat.cmd  <= lat.cmd_in;
         lat.len  <= lat.len_in;
      end
   end

   stable_hold_a: assert property (@(posedge clock) disable iff (!reset_n)
      !lat.load |=> $stable(lat.addr) && $stable(lat.cmd) && $stable(lat.len))
      else $error("latched address fields changed without a load");
endmodule
`default_nettype wire

// *** design/pci_master_read_address_phase.sv ***
`timescale 1ns/100ps
`default_nettype none
module pci_master_read_address_phase #(
   parameter int LEN_W = mrd_addr_pkg::LEN_W
) (
   input  wire logic             clock,
   input  wire logic             reset_n,
   input  wire logic             local_req_wide_n,
   input  wire logic [31:0]      local_addr_in,
   input  wire logic [3:0]       local_cmd_byte_en_in,
   input  wire logic [LEN_W-1:0] local_transfer_length,
   input  wire logic             local_ready_n,
   input  wire logic             data_phase_done,
   input  wire logic             gntn,
   input  wire logic             framen_in,
   input  wire logic             irdyn_in,
   output logic                  local_grant_n,
   output logic [3:0]            local_master_state,
   output logic [LEN_W-1:0]      remaining_transfer_count,
   output logic                  reqn,
   output logic                  framen_out,
   output logic                  framen_oe,
   output logic                  irdyn_out,
   output logic                  irdyn_oe,
   output logic [31:0]           ad_out,
   output logic                  ad_oe,
   output logic [3:0]            cben_out,
   output logic                  cben_oe
);
   // ----------------------------------------
   // state and latch
   // ----------------------------------------
   mrd_addr_pkg::mst_state_t state_r;
   mrd_addr_pkg::mst_state_t state_nxt;
   logic                     bus_idle;

   addr_latch_if #(.LEN_W(LEN_W)) lat ();

   addr_latch u_latch (
      .clock   (clock),
      .reset_n (reset_n),
      .lat     (lat)
   );

   // inputs need only be held until the latch loads them in ST_GRANT
   assign lat.addr_in = local_addr_in;
   assign lat.cmd_in  = local_cmd_byte_en_in;
   assign lat.len_in  = local_transfer_length;
   assign lat.load    = (state_r == mrd_addr_pkg::ST_GRANT) && !local_req_wide_n && !gntn;
   assign bus_idle    = framen_in && irdyn_in;

   // ----------------------------------------
   // sequencer
   // ----------------------------------------
   always_comb begin
      state_nxt = state_r;
      case (state_r)
         mrd_addr_pkg::ST_IDLE: begin
            if (!local_req_wide_n) begin
               state_nxt = mrd_addr_pkg::ST_REQ;
            end
         end
         mrd_addr_pkg::ST_REQ: begin
            if (local_req_wide_n) begin
               state_nxt = mrd_addr_pkg::ST_IDLE;
            end else if (!gntn && bus_idle) begin
               state_nxt = mrd_addr_pkg::ST_GRANT;
            end
         end
         mrd_addr_pkg::ST_GRANT: begin
            if (lat.load) begin
               state_nxt = mrd_addr_pkg::ST_LOAD;
            end else if (local_req_wide_n) begin
               state_nxt = mrd_addr_pkg::ST_IDLE;
            end else begin
               state_nxt = mrd_addr_pkg::ST_REQ;
            end
         end
         mrd_addr_pkg::ST_LOAD: state_nxt = mrd_addr_pkg::ST_ADDR;
         mrd_addr_pkg::ST_ADDR: state_nxt = mrd_addr_pkg::ST_TURN;
         mrd_addr_pkg::ST_TURN: state_nxt = mrd_addr_pkg::ST_DATA;
         mrd_addr_pkg::ST_DATA: begin
            if (data_phase_done) begin
               state_nxt = mrd_addr_pkg::ST_IDLE;
            end
         end
         default: state_nxt = mrd_addr_pkg::ST_IDLE;
      endcase
   end

   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         state_r <= mrd_addr_pkg::ST_IDLE;
      end else begin
         state_r <= state_nxt;
      end
   end

   // ----------------------------------------
   // arbitration and local handshake
   // ----------------------------------------
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         reqn <= 1'b1;
      end else if (state_r == mrd_addr_pkg::ST_IDLE && !local_req_wide_n) begin
         reqn <= 1'b0;
      end else if (state_nxt == mrd_addr_pkg::ST_IDLE) begin
         reqn <= 1'b1;
      end else if (!framen_out && local_req_wide_n) begin
         reqn <= 1'b1; // no further cycle wanted once the frame is under way
      end
   end

   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         local_grant_n <= 1'b1;
      end else begin
         local_grant_n <= !(state_nxt == mrd_addr_pkg::ST_GRANT);
      end
   end

   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         local_master_state <= mrd_addr_pkg::STAT_IDLE;
      end else if (state_nxt == mrd_addr_pkg::ST_LOAD) begin
         local_master_state <= mrd_addr_pkg::STAT_ADDR_LD;
      end else if (state_nxt == mrd_addr_pkg::ST_ADDR) begin
         local_master_state <= mrd_addr_pkg::STAT_BUS_XFER;
      end else if (state_nxt == mrd_addr_pkg::ST_IDLE) begin
         local_master_state <= mrd_addr_pkg::STAT_IDLE;
      end
   end

   // ----------------------------------------
   // pci drive
   // ----------------------------------------
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         ad_out <= mrd_addr_pkg::AD_RST;
         ad_oe  <= 1'b0;
      end else if (state_nxt == mrd_addr_pkg::ST_ADDR) begin
         ad_out <= lat.addr;
         ad_oe  <= 1'b1;
      end else begin
         ad_oe  <= 1'b0; // turnaround releases ad
      end
   end

   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         cben_out <= mrd_addr_pkg::CBE_RST;
         cben_oe  <= 1'b0;
      end else if (state_nxt == mrd_addr_pkg::ST_ADDR) begin
         cben_out <= lat.cmd;
         cben_oe  <= 1'b1;
      end else if (state_nxt == mrd_addr_pkg::ST_TURN) begin
         cben_out <= local_cmd_byte_en_in;
      end else if (state_nxt == mrd_addr_pkg::ST_IDLE) begin
         cben_oe  <= 1'b0;
      end
   end

   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         remaining_transfer_count <= '0;
      end else if (state_nxt == mrd_addr_pkg::ST_ADDR) begin
         remaining_transfer_count <= lat.len;
      end
   end

   // a single-transfer burst ends the frame at turnaround
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         framen_out <= 1'b1;
         framen_oe  <= 1'b0;
      end else if (state_nxt == mrd_addr_pkg::ST_ADDR) begin
         framen_out <= 1'b0;
         framen_oe  <= 1'b1;
      end else if (state_nxt == mrd_addr_pkg::ST_TURN) begin
         framen_out <= !(remaining_transfer_count > LEN_W'(1));
      end else if (state_nxt == mrd_addr_pkg::ST_IDLE) begin
         framen_out <= 1'b1;
         framen_oe  <= 1'b0;
      end
   end

   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         irdyn_out <= 1'b1;
         irdyn_oe  <= 1'b0;
      end else if (state_nxt == mrd_addr_pkg::ST_TURN || state_nxt == mrd_addr_pkg::ST_DATA) begin
         irdyn_out <= local_ready_n;
         irdyn_oe  <= 1'b1;
      end else begin
         irdyn_out <= 1'b1;
         irdyn_oe  <= 1'b0;
      end
   end

   // ----------------------------------------
   // checks
   // ----------------------------------------
   default clocking cb @(posedge clock); endclocking
   default disable iff (!reset_n);

   req_raise_a: assert property ($rose(state_r == mrd_addr_pkg::ST_REQ) |-> !reqn)
      else $error("reqn not low after local request");
   grant_start_a: assert property (state_r == mrd_addr_pkg::ST_REQ && !local_req_wide_n
         && !gntn && bus_idle |=> !local_grant_n)
      else $error("local grant missing after bus grant");
   addr_load_a: assert property (!local_grant_n && !local_req_wide_n && !gntn
         |=> local_master_state == mrd_addr_pkg::STAT_ADDR_LD)
      else $error("status not address loading");
   frame_start_a: assert property (local_master_state == mrd_addr_pkg::STAT_ADDR_LD
         |=> !framen_out && framen_oe)
      else $error("framen not asserted after address loading");
   addr_drive_a: assert property (local_master_state == mrd_addr_pkg::STAT_ADDR_LD
         |=> ad_oe && ad_out == $past(lat.addr) && cben_out == $past(lat.cmd))
      else $error("address or command not driven");
   bus_status_a: assert property ($rose(ad_oe)
         |-> local_master_state == mrd_addr_pkg::STAT_BUS_XFER)
      else $error("status not bus transaction with address");
   count_load_a: assert property ($rose(ad_oe) |-> remaining_transfer_count == $past(lat.len))
      else $error("count not loaded with length");
   turn_ad_a: assert property ($rose(ad_oe) |=> !ad_oe && cben_oe && irdyn_oe
         && cben_out == $past(local_cmd_byte_en_in))
      else $error("turnaround drive wrong");
   turn_irdy_a: assert property ($fell(ad_oe) && state_r == mrd_addr_pkg::ST_TURN
         |-> irdyn_oe && irdyn_out == $past(local_ready_n))
      else $error("irdyn does not follow local ready");
   turn_frame_a: assert property ($fell(ad_oe) && state_r == mrd_addr_pkg::ST_TURN
         |-> framen_out == !($past(remaining_transfer_count) > LEN_W'(1)))
      else $error("framen wrong at turnaround");
endmodule
`default_nettype wire

// *** tb/pci_bus_model.sv ***
`timescale 1ns/100ps
`default_nettype none
// ----------------------------------------
// arbiter and bus lines seen by the core
// ----------------------------------------
module pci_bus_model (
   input  wire logic clock,
   input  wire logic reset_n,
   input  wire logic stall,
   input  wire logic reqn,
   input  wire logic framen_out,
   input  wire logic framen_oe,
   input  wire logic irdyn_out,
   input  wire logic irdyn_oe,
   output logic      gntn,
   output logic      framen_in,
   output logic      irdyn_in
);
   // stall holds the grant off so a request can be withdrawn unanswered
   always_ff @(negedge clock or negedge reset_n) begin
      if (!reset_n) begin
         gntn <= 1'b1;
      end else begin
         gntn <= reqn | stall;
      end
   end
   // pulled-up lines read high once nobody drives them
   assign framen_in = framen_oe ? framen_out : 1'b1;
   assign irdyn_in  = irdyn_oe ? irdyn_out : 1'b1;
endmodule
`default_nettype wire

// *** tb/pci_master_read_address_phase_tb.sv ***
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, e, g) begin \
   checked++; \
   if ((g) !== (e)) begin \
      n_errors++; \
      $display("MISMATCH %s expected %0h seen %0h", nm, e, g); \
   end \
end
module pci_master_read_address_phase_tb;
   // ----------------------------------------
   // signals
   // ----------------------------------------
   logic        clock = 1'b0;
   logic        reset_n = 1'b0;
   logic        local_req_wide_n = 1'b1;
   logic [31:0] local_addr_in = 32'h0000_0000;
   logic [3:0]  local_cmd_byte_en_in = 4'h0;
   logic [15:0] local_transfer_length = 16'h0000;
   logic        local_ready_n = 1'b1;
   logic        data_phase_done = 1'b0;
   logic        stall = 1'b0;
   logic        gntn, framen_in, irdyn_in, local_grant_n, reqn;
   logic        framen_out, framen_oe, irdyn_out, irdyn_oe, ad_oe, cben_oe;
   logic [3:0]  local_master_state, cben_out;
   logic [15:0] remaining_transfer_count;
   logic [31:0] ad_out;
   int          n_errors = 0;
   int          checked = 0;
   always #12.5 clock = ~clock;
   pci_master_read_address_phase dut_u (.clock(clock), .reset_n(reset_n),
      .local_req_wide_n(local_req_wide_n), .local_addr_in(local_addr_in),
      .local_cmd_byte_en_in(local_cmd_byte_en_in), .local_transfer_length(local_transfer_length),
      .local_ready_n(local_ready_n), .data_phase_done(data_phase_done), .gntn(gntn),
      .framen_in(framen_in), .irdyn_in(irdyn_in), .local_grant_n(local_grant_n),
      .local_master_state(local_master_state), .remaining_transfer_count(remaining_transfer_count),
      .reqn(reqn), .framen_out(framen_out), .framen_oe(framen_oe), .irdyn_out(irdyn_out),
      .irdyn_oe(irdyn_oe), .ad_out(ad_out), .ad_oe(ad_oe), .cben_out(cben_out),
      .cben_oe(cben_oe));
   pci_bus_model bus_u (.clock(clock), .reset_n(reset_n), .stall(stall), .reqn(reqn),
      .framen_out(framen_out), .framen_oe(framen_oe), .irdyn_out(irdyn_out),
      .irdyn_oe(irdyn_oe), .gntn(gntn), .framen_in(framen_in), .irdyn_in(irdyn_in));
   // ----------------------------------------
   // closing
   // ----------------------------------------
   task automatic conclude;
      $display("errors %0d checks %0d", n_errors, checked);
      if (n_errors == 0 && checked > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   // one full address phase; address and length inputs are scrambled after loading to prove the latch
   task automatic xfer(input logic [31:0] a, input logic [3:0] c, input logic [15:0] n,
                       input logic [3:0] be, input logic rdy);
      int k;
      k = 0;
      local_addr_in = a;
      local_cmd_byte_en_in = c;
      local_transfer_length = n;
      local_req_wide_n = 1'b0;
      while (local_grant_n !== 1'b0 && k < 20) begin
         @(negedge clock);
         k++;
      end
      `CHK("local grant", 1'b0, local_grant_n)
      @(negedge clock);
      `CHK("state load", mrd_addr_pkg::STAT_ADDR_LD, local_master_state)
      `CHK("grant one cycle", 1'b1, local_grant_n)
      local_addr_in = ~a;
      local_transfer_length = ~n;
      @(negedge clock);
      `CHK("frame low", 2'b10, {framen_oe, framen_out})
      `CHK("address", {1'b1, a}, {ad_oe, ad_out})
      `CHK("command", {1'b1, c}, {cben_oe, cben_out})
      `CHK("state xfer", mrd_addr_pkg::STAT_BUS_XFER, local_master_state)
      `CHK("burst count", n, remaining_transfer_count)
      local_cmd_byte_en_in = be;
      local_ready_n = rdy;
      local_req_wide_n = 1'b1;
      @(negedge clock);
      `CHK("ad released", 1'b0, ad_oe)
      `CHK("byte enables", {1'b1, be}, {cben_oe, cben_out})
      `CHK("irdy", {1'b1, rdy}, {irdyn_oe, irdyn_out})
      `CHK("frame kept", (n > 16'h0001) ? 1'b0 : 1'b1, framen_out)
      local_ready_n = 1'b1;
      @(negedge clock);
      `CHK("state holds", mrd_addr_pkg::STAT_BUS_XFER, local_master_state)
      `CHK("irdy follows", 2'b11, {irdyn_oe, irdyn_out})
      data_phase_done = 1'b1;
      @(negedge clock);
      data_phase_done = 1'b0;
      `CHK("back idle", mrd_addr_pkg::STAT_IDLE, local_master_state)
      `CHK("bus released", 4'h0, {framen_oe, ad_oe, cben_oe, irdyn_oe})
   endtask
   // request withdrawn while the arbiter withholds the grant
   task automatic withdraw;
      stall = 1'b1;
      local_req_wide_n = 1'b0;
      repeat (3) @(negedge clock);
      `CHK("req raised", 1'b0, reqn)
      `CHK("no grant", 1'b1, local_grant_n)
      `CHK("no load", mrd_addr_pkg::STAT_IDLE, local_master_state)
      local_req_wide_n = 1'b1;
      repeat (2) @(negedge clock);
      `CHK("req dropped", 1'b1, reqn)
      `CHK("frame idle", 1'b0, framen_oe)
      stall = 1'b0;
      @(negedge clock);
   endtask
   // ----------------------------------------
   // main sequence and watchdog
   // ----------------------------------------
   initial begin
      repeat (10) @(negedge clock);
      `CHK("reset outputs", 4'hf, {reqn, local_grant_n, framen_out, irdyn_out})
      `CHK("reset enables", 4'h0, {framen_oe, irdyn_oe, ad_oe, cben_oe})
      reset_n = 1'b1;
      @(negedge clock);
      xfer(32'h1234_5678, 4'h6, 16'h0004, 4'h0, 1'b0);
      xfer(32'hfedc_ba98, 4'hc, 16'h0001, 4'ha, 1'b1);
      withdraw();
      xfer(32'h0000_0ffc, 4'he, 16'hffff, 4'h3, 1'b0);
      conclude();
   end
   // whole run is under 50 cycles; 4000 leaves ample margin
   initial begin
      #(25 * 4000);
      n_errors++;
      conclude();
   end
endmodule
`default_nettype wire
